// ==== src/atd_params.svh ====
`ifndef ATD_PARAMS_SVH
`define ATD_PARAMS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ATD_OFS_CTRL 4'h0
`define ATD_OFS_DPTR 4'h4
`define ATD_OFS_STAT 4'h8
`define ATD_OFS_BLKS 4'hC
`define ATD_CTRL_RUN 0
`define ATD_CTRL_RESP 1
`define ATD_CTRL_RST 1'h0
`define ATD_DPTR_RST 32'h0000_0000
`define ATD_STAT_BUSY 0
`define ATD_STAT_STOP 1
`define ATD_STAT_EXPIRED 2

// ----------------------------------------------------------------
// descriptor fields
// ----------------------------------------------------------------
`define ATD_CMD_HI 31
`define ATD_CMD_LO 28
`define ATD_KEY_HI 27
`define ATD_KEY_LO 25
`define ATD_CNT_HI 15
`define ATD_CNT_LO 0
`define ATD_DL_HI 15
`define ATD_DL_LO 0
`define ATD_CMD_MORE 4'h0
`define ATD_KEY_FRAG 3'h0
`define ATD_KEY_IMM 3'h2

// ----------------------------------------------------------------
// sizes and counts
// ----------------------------------------------------------------
`define ATD_FRAG_BYTES 32'h0000_0010
`define ATD_IMM_BYTES 32'h0000_0020
`define ATD_IMM_OFS 32'h0000_0010
`define ATD_QUAD_ADDR 32'h0000_0004
`define ATD_QUAD_BYTES 16'h0004
`define ATD_FRAG_BLKS 4'h1
`define ATD_IMM_BLKS 4'h2
`define ATD_LAST_HDR_QUAD 2'h3

`endif

// ==== src/atd_pkg.sv ====
package atd_pkg;

	typedef enum logic [2:0] {
		ATD_IDLE,
		ATD_HDR_RD,
		ATD_DECODE,
		ATD_DATA_RD,
		ATD_DATA_PUSH
	} atd_state_t;

	typedef enum logic [1:0] {
		ATD_KIND_NONE,
		ATD_KIND_FRAG,
		ATD_KIND_IMM
	} atd_kind_t;

endpackage

// ==== src/atd_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "atd_params.svh"

module atd_regs
	import atd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic busy,
	input wire logic stopped,
	input wire logic expired,
	input wire logic [31:0] cur_ptr,
	input wire logic [3:0] blocks,
	output logic start,
	output logic resp_ctx,
	output logic [31:0] start_ptr
);

	logic wait_r;
	logic [31:0] rdata_r;
	logic start_r;
	logic resp_r;
	logic [31:0] dptr_r;
	logic take;

	assign take = (avs_read | avs_write) & ~wait_r;
	assign avs_waitrequest = wait_r;
	assign avs_readdata = rdata_r;
	assign start = start_r;
	assign resp_ctx = resp_r;
	assign start_ptr = dptr_r;

	// ----------------------------------------------------------------
	// one wait cycle, then the answer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wait_r <= 1'b1;
		end else begin
			wait_r <= ~((avs_read | avs_write) & wait_r);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata_r <= 32'h0000_0000;
		end else if ((avs_read | avs_write) & wait_r) begin
			unique case (avs_address)
				`ATD_OFS_CTRL: rdata_r <= {30'h0000_0000, resp_r, busy};
				`ATD_OFS_DPTR: rdata_r <= cur_ptr;
				`ATD_OFS_STAT: rdata_r <= {29'h0000_0000, expired, stopped, busy};
				`ATD_OFS_BLKS: rdata_r <= {28'h000_0000, blocks};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// writes take effect on the answering edge
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			start_r <= 1'b0;
			resp_r <= `ATD_CTRL_RST;
			dptr_r <= `ATD_DPTR_RST;
		end else begin
			start_r <= 1'b0;
			if (take & avs_write) begin
				if (avs_address == `ATD_OFS_CTRL) begin
					start_r <= avs_writedata[`ATD_CTRL_RUN];
					if (!busy) begin
						resp_r <= avs_writedata[`ATD_CTRL_RESP];
					end
				end
				if (avs_address == `ATD_OFS_DPTR && !busy) begin
					dptr_r <= avs_writedata;
				end
			end
		end
	end

endmodule
`default_nettype wire

// ==== src/atd_decode.sv ====
// Operation
// [R1] command 0 with type tag 0 is a buffer fragment descriptor
// [R2] software keeps the flow selector field at zero
// [R3] fragment: read request_byte_count bytes starting at buffer_pointer
// [R4] fragment bytes go into the owning context's transmit FIFO
// [R5] command 0 with type tag 2 is an inline-header descriptor
// [R6] inline header bytes start right after the first sixteen bytes
// [R7] software sets inline request_byte_count to eight or sixteen
// [R8] inline-header descriptor always advances the pointer by 32 bytes
// [R9] send_deadline used only in response context: seconds low 3, ticks 13
// [R10] response packet past its send_deadline is not transmitted
// [R11] inline header quadlets go into the owning context's FIFO
// [R12] software uses inline headers only for allowed packet kinds
// [R13] each inline-header descriptor counts as two 16-byte blocks
// [R14] software keeps a descriptor block within 128 bytes
// [R15] software aligns descriptors on 16-byte boundaries
// [R16] data is pushed in descriptor order
`timescale 1ns/1ns
`default_nettype none
`include "atd_params.svh"

module atd_decode
	import atd_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic mem_rd_req,
	output logic [31:0] mem_rd_addr,
	input wire logic mem_rd_valid,
	input wire logic [31:0] mem_rd_data,
	output logic fifo_valid,
	output logic [31:0] fifo_data,
	output logic [2:0] fifo_bytes,
	output logic fifo_resp,
	input wire logic fifo_ready,
	input wire logic [6:0] timer_second_count,
	input wire logic [12:0] timer_cycle_tick
);

	atd_state_t state_r;
	atd_kind_t kind_r;
	logic [31:0] ptr_r;
	logic [31:0] next_ptr_r;
	logic [31:0] rd_addr_r;
	logic rd_req_r;
	logic [15:0] rem_r;
	logic [1:0] idx_r;
	logic [31:0] hdr_r [0:3];
	logic [3:0] blocks_r;
	logic skip_r;
	logic stop_r;
	logic expired_r;
	logic fvalid_r;
	logic [31:0] fdata_r;
	logic [2:0] fbytes_r;
	logic start;
	logic resp_ctx;
	logic [31:0] start_ptr;
	logic [3:0] cmd_w;
	logic [2:0] key_w;
	logic [15:0] cnt_w;
	logic [15:0] dl_w;
	logic [15:0] now_w;
	logic [15:0] late_w;
	logic is_frag;
	logic is_imm;
	logic passed;
	logic [2:0] word_bytes;
	logic last_word;

	atd_regs u_regs (
		.ref_clk(ref_clk),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.busy(state_r != ATD_IDLE),
		.stopped(stop_r),
		.expired(expired_r),
		.cur_ptr(ptr_r),
		.blocks(blocks_r),
		.start(start),
		.resp_ctx(resp_ctx),
		.start_ptr(start_ptr)
	);

	assign mem_rd_req = rd_req_r;
	assign mem_rd_addr = rd_addr_r;
	assign fifo_valid = fvalid_r;
	assign fifo_data = fdata_r;
	assign fifo_bytes = fbytes_r;
	assign fifo_resp = resp_ctx;

	// ----------------------------------------------------------------
	// descriptor field decode
	// ----------------------------------------------------------------
	assign cmd_w = hdr_r[0][`ATD_CMD_HI:`ATD_CMD_LO];
	assign key_w = hdr_r[0][`ATD_KEY_HI:`ATD_KEY_LO];
	assign cnt_w = hdr_r[0][`ATD_CNT_HI:`ATD_CNT_LO];
	assign dl_w = hdr_r[3][`ATD_DL_HI:`ATD_DL_LO];
	assign is_frag = (cmd_w == `ATD_CMD_MORE) && (key_w == `ATD_KEY_FRAG); // [R1]
	assign is_imm = (cmd_w == `ATD_CMD_MORE) && (key_w == `ATD_KEY_IMM); // [R5]
	// deadline is low seconds bits over the full tick count
	assign now_w = {timer_second_count[2:0], timer_cycle_tick}; // [R9]
	assign late_w = 16'(now_w - dl_w);
	// passed when now lies in the half range after the deadline
	assign passed = resp_ctx && (late_w != 16'h0000) && !late_w[15]; // [R9]
	assign word_bytes = (rem_r < `ATD_QUAD_BYTES) ? rem_r[2:0] : 3'h4;
	assign last_word = (rem_r <= `ATD_QUAD_BYTES);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_r <= ATD_IDLE;
			idx_r <= 2'h0;
		end else begin
			unique case (state_r)
				ATD_IDLE: begin
					if (start) begin
						state_r <= ATD_HDR_RD;
						idx_r <= 2'h0;
					end
				end
				ATD_HDR_RD: begin
					if (mem_rd_valid) begin
						idx_r <= 2'(idx_r + 2'h1);
						if (idx_r == `ATD_LAST_HDR_QUAD) begin
							state_r <= ATD_DECODE;
						end
					end
				end
				ATD_DECODE: begin
					if (!is_frag && !is_imm) begin
						state_r <= ATD_IDLE;
					end else if (skip_r || (is_imm && passed) || cnt_w == 16'h0000) begin
						state_r <= ATD_HDR_RD; // [R10]
					end else begin
						state_r <= ATD_DATA_RD;
					end
				end
				ATD_DATA_RD: begin
					if (mem_rd_valid) begin
						state_r <= ATD_DATA_PUSH;
					end
				end
				ATD_DATA_PUSH: begin
					// next word is read only after this one is taken
					if (fifo_ready) begin
						state_r <= last_word ? ATD_HDR_RD : ATD_DATA_RD; // [R16]
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// host memory reads
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_req_r <= 1'b0;
			rd_addr_r <= 32'h0000_0000;
		end else begin
			if (mem_rd_valid) begin
				rd_req_r <= 1'b0;
			end
			unique case (state_r)
				ATD_IDLE: begin
					if (start) begin
						rd_req_r <= 1'b1;
						rd_addr_r <= start_ptr;
					end
				end
				ATD_HDR_RD: begin
					if (mem_rd_valid && idx_r != `ATD_LAST_HDR_QUAD) begin
						rd_req_r <= 1'b1;
						rd_addr_r <= rd_addr_r + `ATD_QUAD_ADDR;
					end
				end
				ATD_DECODE: begin
					if (is_frag || is_imm) begin
						rd_req_r <= 1'b1;
						if (skip_r || (is_imm && passed) || cnt_w == 16'h0000) begin
							rd_addr_r <= is_imm ? ptr_r + `ATD_IMM_BYTES
								: ptr_r + `ATD_FRAG_BYTES; // [R8]
						end else if (is_imm) begin
							rd_addr_r <= ptr_r + `ATD_IMM_OFS; // [R6]
						end else begin
							rd_addr_r <= hdr_r[1]; // [R3]
						end
					end
				end
				ATD_DATA_RD: begin
				end
				ATD_DATA_PUSH: begin
					if (fifo_ready) begin
						rd_req_r <= 1'b1;
						rd_addr_r <= last_word ? next_ptr_r
							: rd_addr_r + `ATD_QUAD_ADDR; // [R3]
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// descriptor capture and walk state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (state_r == ATD_HDR_RD && mem_rd_valid) begin
			hdr_r[idx_r] <= mem_rd_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ptr_r <= 32'h0000_0000;
			next_ptr_r <= 32'h0000_0000;
			kind_r <= ATD_KIND_NONE;
			rem_r <= 16'h0000;
			blocks_r <= 4'h0;
			skip_r <= 1'b0;
			stop_r <= 1'b0;
			expired_r <= 1'b0;
		end else begin
			if (state_r == ATD_IDLE && start) begin
				ptr_r <= start_ptr;
				blocks_r <= 4'h0;
				skip_r <= 1'b0;
				stop_r <= 1'b0;
				expired_r <= 1'b0;
			end
			if (state_r == ATD_DECODE) begin
				if (!is_frag && !is_imm) begin
					stop_r <= 1'b1;
					kind_r <= ATD_KIND_NONE;
				end else if (is_imm) begin
					kind_r <= ATD_KIND_IMM;
					rem_r <= cnt_w;
					blocks_r <= 4'(blocks_r + `ATD_IMM_BLKS); // [R13]
					next_ptr_r <= ptr_r + `ATD_IMM_BYTES; // [R8]
					if (passed) begin
						skip_r <= 1'b1; // [R10]
						expired_r <= 1'b1;
					end
				end else begin
					kind_r <= ATD_KIND_FRAG;
					rem_r <= cnt_w; // [R3]
					blocks_r <= 4'(blocks_r + `ATD_FRAG_BLKS); // [R13]
					next_ptr_r <= ptr_r + `ATD_FRAG_BYTES;
				end
				if ((is_frag || is_imm)
						&& (skip_r || (is_imm && passed) || cnt_w == 16'h0000)) begin
					ptr_r <= is_imm ? ptr_r + `ATD_IMM_BYTES
						: ptr_r + `ATD_FRAG_BYTES; // [R8]
				end
			end
			if (state_r == ATD_DATA_PUSH && fifo_ready) begin
				rem_r <= 16'(rem_r - {13'h0000, word_bytes});
				if (last_word) begin
					ptr_r <= next_ptr_r;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit FIFO output
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fvalid_r <= 1'b0;
			fdata_r <= 32'h0000_0000;
			fbytes_r <= 3'h0;
		end else begin
			if (state_r == ATD_DATA_RD && mem_rd_valid) begin
				fvalid_r <= 1'b1; // [R4] [R11]
				fdata_r <= mem_rd_data;
				fbytes_r <= word_bytes;
			end else if (state_r == ATD_DATA_PUSH && fifo_ready) begin
				fvalid_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_frag_go;
		state_r == ATD_DECODE && is_frag && !skip_r && cnt_w != 16'h0000;
	endsequence

	sequence s_imm_go;
		state_r == ATD_DECODE && is_imm && !passed && !skip_r
			&& cnt_w != 16'h0000;
	endsequence

	property p_frag_addr;
		@(posedge ref_clk) disable iff (srst)
		s_frag_go |=> rd_req_r && rd_addr_r == $past(hdr_r[1])
			&& rem_r == $past(cnt_w);
	endproperty
	a_frag_addr: assert property (p_frag_addr) // [R3]
		else $error("fragment read not at buffer pointer");

	property p_imm_addr;
		@(posedge ref_clk) disable iff (srst)
		s_imm_go |=> rd_addr_r == $past(ptr_r) + `ATD_IMM_OFS
			&& state_r == ATD_DATA_RD;
	endproperty
	a_imm_addr: assert property (p_imm_addr) // [R6]
		else $error("inline header read not after first sixteen bytes");

	property p_imm_next;
		@(posedge ref_clk) disable iff (srst)
		state_r == ATD_DECODE && is_imm |=> next_ptr_r == $past(ptr_r) + 32'h20;
	endproperty
	a_imm_next: assert property (p_imm_next) // [R8]
		else $error("inline descriptor step not 32 bytes");

	property p_blocks;
		@(posedge ref_clk) disable iff (srst)
		state_r == ATD_DECODE && is_imm |=> blocks_r == 4'($past(blocks_r) + 4'h2);
	endproperty
	a_blocks: assert property (p_blocks) // [R13]
		else $error("inline descriptor not counted as two blocks");

	property p_expired;
		@(posedge ref_clk) disable iff (srst)
		state_r == ATD_DECODE && is_imm && passed
			|=> !fvalid_r && skip_r && state_r == ATD_HDR_RD;
	endproperty
	a_expired: assert property (p_expired) // [R10]
		else $error("expired response packet not dropped");

	property p_no_push_skip;
		@(posedge ref_clk) disable iff (srst)
		skip_r |-> !(state_r == ATD_DATA_RD);
	endproperty
	a_no_push_skip: assert property (p_no_push_skip) // [R10]
		else $error("data fetched for a dropped packet");

	property p_req_hold;
		@(posedge ref_clk) disable iff (srst)
		rd_req_r && !mem_rd_valid |=> rd_req_r && $stable(rd_addr_r);
	endproperty
	a_req_hold: assert property (p_req_hold) // [R3]
		else $error("memory request dropped before answer");

	property p_push_hold;
		@(posedge ref_clk) disable iff (srst)
		fvalid_r && !fifo_ready |=> fvalid_r && $stable(fdata_r);
	endproperty
	a_push_hold: assert property (p_push_hold) // [R16]
		else $error("fifo word changed before taken");

	property p_push_ctx;
		@(posedge ref_clk) disable iff (srst)
		fvalid_r |-> $stable(fifo_resp) && fbytes_r != 3'h0
			&& fbytes_r <= 3'h4
			&& (kind_r != ATD_KIND_IMM || fbytes_r == 3'h4);
	endproperty
	a_push_ctx: assert property (p_push_ctx) // [R4] [R11]
		else $error("fifo word has bad byte count");

	property p_unknown_stop;
		@(posedge ref_clk) disable iff (srst)
		state_r == ATD_DECODE && !is_frag && !is_imm
			|=> state_r == ATD_IDLE && stop_r ##1 !fvalid_r;
	endproperty
	a_unknown_stop: assert property (p_unknown_stop) // [R1]
		else $error("unrecognised descriptor not stopped");

endmodule
`default_nettype wire

// ==== test/atd_host_mem.sv ====
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// host memory holding descriptor lists and buffers
// ----------------------------------------------------------------
module atd_host_mem (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic mem_rd_req,
	input wire logic [31:0] mem_rd_addr,
	output logic mem_rd_valid,
	output logic [31:0] mem_rd_data
);
	logic [31:0] mem [0:1023];
	logic [31:0] addr_log [$];
	logic [1:0] wait_r;
	logic slow_r;

	// answers alternate between prompt and slow; data line is junk between
	always @(posedge ref_clk) begin
		if (srst) begin
			mem_rd_valid <= 1'b0;
			mem_rd_data <= 32'hA5A5_5A5A;
			wait_r <= 2'h0;
			slow_r <= 1'b0;
		end else if (mem_rd_valid) begin
			mem_rd_valid <= 1'b0;
			mem_rd_data <= ~mem_rd_data;
		end else if (mem_rd_req) begin
			if (wait_r == (slow_r ? 2'h3 : 2'h0)) begin
				mem_rd_valid <= 1'b1;
				mem_rd_data <= mem[mem_rd_addr[11:2]];
				addr_log.push_back(mem_rd_addr);
				wait_r <= 2'h0;
				slow_r <= ~slow_r;
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end else begin
			mem_rd_data <= ~mem_rd_data;
		end
	end
endmodule

`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "atd_params.svh"

module testbench;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic mem_rd_req, mem_rd_valid, fifo_valid, fifo_resp;
	logic [31:0] mem_rd_addr, mem_rd_data, fifo_data;
	logic [2:0] fifo_bytes;
	logic fifo_ready = 1'b0;
	logic [6:0] timer_second_count = 7'h05;
	logic [12:0] timer_cycle_tick = 13'h0064;
	logic [3:0] stall_r = 4'h0;
	logic [35:0] got [$];
	logic [35:0] exp_q [$];
	logic [31:0] rd;
	int miscompares = 0;
	int checks = 0;

	always #2 ref_clk = ~ref_clk;

	atd_decode i_dut (.ref_clk(ref_clk), .srst(srst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.fifo_valid(fifo_valid), .fifo_data(fifo_data),
		.fifo_bytes(fifo_bytes), .fifo_resp(fifo_resp),
		.fifo_ready(fifo_ready), .timer_second_count(timer_second_count),
		.timer_cycle_tick(timer_cycle_tick));

	atd_host_mem i_mem (.ref_clk(ref_clk), .srst(srst),
		.mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
		.mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

	// ----------------------------------------------------------------
	// transmit FIFO sink that stalls now and then
	// ----------------------------------------------------------------
	always @(posedge ref_clk) begin
		stall_r <= stall_r + 4'h1;
		fifo_ready <= (stall_r[1:0] != 2'h3);
		if (fifo_valid && fifo_ready)
			got.push_back({fifo_resp, fifo_bytes, fifo_data});
	end

	task close_out;
		if (miscompares == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [35:0] seen, input logic [35:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task put(input logic [31:0] a, input logic [31:0] d);
		i_mem.mem[a[11:2]] = d;
	endtask

	// software-built descriptor: flow selector and reserved bits zero
	task desc(input logic [31:0] a, input logic [6:0] ck,
			input logic [15:0] cnt, input logic [31:0] ptr,
			input logic [15:0] dl);
		put(a, {ck, 9'h000, cnt});
		put(a + 32'h4, ptr);
		put(a + 32'h8, 32'h0000_0000);
		put(a + 32'hC, {16'h0000, dl});
	endtask

	task walk(input logic [31:0] p, input logic resp, input logic [2:0] st);
		int n;
		got.delete();
		i_mem.addr_log.delete();
		bus(1'b1, `ATD_OFS_DPTR, p);
		bus(1'b1, `ATD_OFS_CTRL, {30'h0, resp, 1'b1});
		n = 0;
		do begin
			bus(1'b0, `ATD_OFS_STAT, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 200);
		if (n >= 200)
			miscompares++;
		chk({33'h0, rd[2:0]}, {33'h0, st});
		chk(36'(got.size()), 36'(exp_q.size()));
		foreach (exp_q[i])
			if (i < got.size())
				chk(got[i], exp_q[i]);
		exp_q.delete();
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		miscompares++;
		close_out;
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, 4'(4 * i), 32'h0);
			chk({4'h0, rd}, 36'h0);
		end
		// ----------------------------------------------------------------
		// request ctx: inline 4 quads, fragment of 6 bytes, then stop
		// ----------------------------------------------------------------
		desc(32'h100, 7'h02, 16'h0010, 32'h0, 16'hA05A);
		for (int i = 0; i < 4; i++) begin
			put(32'h110 + 4 * i, 32'h1100_0000 + i);
			exp_q.push_back({1'b0, 3'h4, 32'h1100_0000 + i});
		end
		desc(32'h120, 7'h00, 16'h0006, 32'h400, 16'h0);
		put(32'h400, 32'hCAFE_0001);
		put(32'h404, 32'hCAFE_0002);
		exp_q.push_back({1'b0, 3'h4, 32'hCAFE_0001});
		exp_q.push_back({1'b0, 3'h2, 32'hCAFE_0002});
		desc(32'h130, 7'h10, 16'h0004, 32'h0, 16'h0);
		walk(32'h100, 1'b0, 3'h2);
		chk({4'h0, i_mem.addr_log[8]}, 36'h120);
		chk({4'h0, i_mem.addr_log[12]}, 36'h400);
		chk({4'h0, i_mem.addr_log[13]}, 36'h404);
		bus(1'b0, `ATD_OFS_BLKS, 32'h0);
		chk({4'h0, rd}, 36'h3);
		bus(1'b0, `ATD_OFS_DPTR, 32'h0);
		chk({4'h0, rd}, 36'h130);
		// ----------------------------------------------------------------
		// response ctx: two quads, deadline ahead
		// ----------------------------------------------------------------
		desc(32'h200, 7'h02, 16'h0008, 32'h0, 16'hA44C);
		put(32'h210, 32'h2200_0000);
		put(32'h214, 32'h2200_0001);
		exp_q.push_back({1'b1, 3'h4, 32'h2200_0000});
		exp_q.push_back({1'b1, 3'h4, 32'h2200_0001});
		// zero-count fragment is stepped over without a data read
		desc(32'h220, 7'h00, 16'h0000, 32'h600, 16'h0);
		desc(32'h230, 7'h10, 16'h0004, 32'h0, 16'h0);
		walk(32'h200, 1'b1, 3'h2);
		chk(36'(i_mem.addr_log.size()), 36'hE);
		bus(1'b0, `ATD_OFS_DPTR, 32'h0);
		chk({4'h0, rd}, 36'h230);
		bus(1'b0, `ATD_OFS_BLKS, 32'h0);
		chk({4'h0, rd}, 36'h3);
		// ----------------------------------------------------------------
		// response ctx: deadline passed, nothing may be sent
		// ----------------------------------------------------------------
		desc(32'h300, 7'h02, 16'h0010, 32'h0, 16'hA05A);
		desc(32'h320, 7'h00, 16'h0004, 32'h500, 16'h0);
		desc(32'h330, 7'h10, 16'h0004, 32'h0, 16'h0);
		walk(32'h300, 1'b1, 3'h6);
		chk({34'h0, rd[2:1]}, {34'h0, 2'h3});
		chk(36'(i_mem.addr_log.size()), 36'hC);
		close_out;
	end
endmodule

`default_nettype wire
